// file: logic/i2wp_defs.svh
`ifndef I2WP_DEFS_SVH
`define I2WP_DEFS_SVH
// slave address upper six bits, low bit comes from the select pin
`define I2WP_ADDR_HI      6'h1e
`define I2WP_RW_WRITE     1'h0
`define I2WP_CTRL_CO_BIT  7
`define I2WP_CTRL_DC_BIT  6
`define I2WP_NUM_COLS     132
`define I2WP_NUM_PAGES    8
`define I2WP_COL_RESET    8'h00
`define I2WP_PAGE_RESET   3'h0
`define I2WP_BYTE_BITS    4'h8
`endif

// file: logic/i2wp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module i2wp_pin_sync (
  input  wire logic   clk_sys,
  input  wire logic   arst_n,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  i2wp_pins_if.sync   pins
);
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;
  logic       scl_s_q, scl_s_d;
  logic       sda_s_q, sda_s_d;

  // a level counts once stages two and three agree, filtering one-cycle glitches
  always_comb begin
    scl_d   = {scl_q[1:0], scl_in};
    sda_d   = {sda_q[1:0], sda_in};
    scl_s_d = (scl_q[2] == scl_q[1]) ? scl_q[2] : scl_s_q;
    sda_s_d = (sda_q[2] == sda_q[1]) ? sda_q[2] : sda_s_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q   <= 3'h7;
      sda_q   <= 3'h7;
      scl_s_q <= 1'h1;
      sda_s_q <= 1'h1;
    end else begin
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
    end
  end

  assign pins.scl_rise  = scl_s_d & ~scl_s_q;
  assign pins.scl_fall  = ~scl_s_d & scl_s_q;
  assign pins.start_det = scl_s_q & scl_s_d & sda_s_q & ~sda_s_d;
  assign pins.stop_det  = scl_s_q & scl_s_d & ~sda_s_q & sda_s_d;
  // current filtered level: an ack release may meet the next scl rise in one cycle
  assign pins.sda_lvl   = sda_s_d;
endmodule : i2wp_pin_sync
`default_nettype wire

// file: logic/i2wp_pins_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2wp_pins_if;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_lvl;
  modport sync (output scl_rise, output scl_fall, output start_det, output stop_det,
                output sda_lvl);
  modport core (input scl_rise, input scl_fall, input start_det, input stop_det,
                input sda_lvl);
endinterface : i2wp_pins_if
`default_nettype wire

// file: logic/i2wp_pkg.sv
package i2wp_pkg;
  typedef enum logic [2:0] {
    I2WP_IDLE,
    I2WP_ADDR,
    I2WP_CTRL,
    I2WP_DATA,
    I2WP_IGNORE
  } i2wp_state_t;
endpackage : i2wp_pkg

// file: logic/i2wp_write_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2wp_defs.svh"
// How it works
// - sda falling while scl high starts a transfer and address reception.
// - answer only address 011110 plus the select pin level.
// - the bit after the address must be zero, meaning write.
// - ack the address byte by pulling sda low during ninth clock high.
// - after address comes a control byte: continuation, data/command, six zeros.
// - continuation zero means all later bytes are data until stop.
// - data/command zero sends byte to commands, one stores it into display ram.
// - column pointer steps by one after every display byte, holding at the last column.
// - control and data bytes are acknowledged too.
// - sda rising while scl high ends the transfer.
// - one bit per scl period, sampled on the rising edge.
// - display ram is 132 columns by eight pages of eight rows.
// - byte fills one page column, bit 0 top row, bit 7 bottom row.
// - ack leaves on its own output pin, joined to the input outside.
// - hardware reset clears the shift register and pointers.
// - the data/command select pin acts as address select bit.
module i2wp_write_port
  import i2wp_pkg::*;
#(
  parameter int COLS  = `I2WP_NUM_COLS,
  parameter int PAGES = `I2WP_NUM_PAGES
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       hw_reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       addr_select_bit,
  output logic            sda_out,
  output logic            sda_out_oe,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  input  wire logic [7:0] col_load,
  input  wire logic       col_load_en,
  input  wire logic [2:0] page_load,
  input  wire logic       page_load_en,
  input  wire logic [7:0] rd_col,
  input  wire logic [2:0] rd_page,
  output logic [7:0]      rd_data,
  output logic [7:0]      col_ptr,
  output logic [2:0]      page_ptr,
  output logic            busy
);
  i2wp_pins_if pins ();

  i2wp_pin_sync u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .pins    (pins)
  );

  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b[7:1] == {`I2WP_ADDR_HI, sel}) && (b[0] == `I2WP_RW_WRITE);
  endfunction : addr_match

  ////////////////////////////////////////////////////////////////////////////
  // protocol state
  i2wp_state_t  st_q, st_d;
  logic [7:0]   sh_q, sh_d;
  logic [3:0]   cnt_q, cnt_d;
  logic         ackph_q, ackph_d;
  logic         ackon_q, ackon_d;
  logic         co_q, co_d;
  logic         dc_q, dc_d;
  logic         cv_q, cv_d;
  logic [7:0]   cb_q, cb_d;
  logic         wr_d;
  logic [7:0]   col_q, col_d;
  logic [2:0]   pg_q, pg_d;
  logic         busy_q, busy_d;
  logic         sw_rst;

  assign sw_rst = ~hw_reset_n; // synchronous clear

  always_comb begin
    st_d    = st_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    ackph_d = ackph_q;
    ackon_d = ackon_q;
    co_d    = co_q;
    dc_d    = dc_q;
    cv_d    = 1'h0;
    cb_d    = cb_q;
    wr_d    = 1'h0;
    col_d   = col_q;
    pg_d    = pg_q;
    if (col_load_en) begin
      col_d = col_load;
    end
    if (page_load_en) begin
      pg_d = page_load;
    end
    if (pins.start_det) begin
      st_d    = I2WP_ADDR;
      cnt_d   = 4'h0;
      ackph_d = 1'h0;
      ackon_d = 1'h0;
      co_d    = 1'h1;
    end else if (pins.stop_det) begin
      st_d    = I2WP_IDLE;
      ackph_d = 1'h0;
      ackon_d = 1'h0;
    end else if (st_q != I2WP_IDLE && st_q != I2WP_IGNORE) begin
      if (pins.scl_rise && !ackph_q) begin
        sh_d  = {sh_q[6:0], pins.sda_lvl}; // msb first
        cnt_d = cnt_q + 4'h1;
      end
      if (pins.scl_fall && !ackph_q && cnt_q == `I2WP_BYTE_BITS) begin
        // byte complete: decide ack and what the byte was
        ackph_d = 1'h1;
        cnt_d   = 4'h0;
        ackon_d = 1'h1;
        case (st_q)
          I2WP_ADDR: begin
            if (addr_match(sh_q, addr_select_bit)) begin
              st_d = I2WP_CTRL;
            end else begin
              st_d    = I2WP_IGNORE;
              ackon_d = 1'h0;
              ackph_d = 1'h0;
            end
          end
          I2WP_CTRL: begin
            co_d = sh_q[`I2WP_CTRL_CO_BIT];
            dc_d = sh_q[`I2WP_CTRL_DC_BIT];
            st_d = I2WP_DATA;
          end
          I2WP_DATA: begin
            if (dc_q) begin
              wr_d = 1'h1;
              // pointer stops at last column rather than wrapping
              if (col_q < 8'(COLS - 1)) begin
                col_d = col_q + 8'h01;
              end
            end else begin
              cv_d = 1'h1; // unchanged, no pointer step
              cb_d = sh_q;
            end
            st_d = co_q ? I2WP_CTRL : I2WP_DATA;
          end
          default: begin
            st_d = st_q;
          end
        endcase
      end else if (pins.scl_fall && ackph_q) begin
        // release after the ninth clock low edge, so sda held across its high
        ackph_d = 1'h0;
        ackon_d = 1'h0;
      end
    end
    if (sw_rst) begin
      st_d    = I2WP_IDLE;
      sh_d    = 8'h00;
      cnt_d   = 4'h0;
      ackph_d = 1'h0;
      ackon_d = 1'h0;
      col_d   = `I2WP_COL_RESET;
      pg_d    = `I2WP_PAGE_RESET;
      wr_d    = 1'h0;
      cv_d    = 1'h0;
    end
    // registered so the output comes straight from a flop
    busy_d = (st_d != I2WP_IDLE) && (st_d != I2WP_IGNORE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= I2WP_IDLE;
      sh_q    <= 8'h00;
      cnt_q   <= 4'h0;
      ackph_q <= 1'h0;
      ackon_q <= 1'h0;
      co_q    <= 1'h1;
      dc_q    <= 1'h0;
      cv_q    <= 1'h0;
      cb_q    <= 8'h00;
      col_q   <= `I2WP_COL_RESET;
      pg_q    <= `I2WP_PAGE_RESET;
      busy_q  <= 1'h0;
    end else begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      ackph_q <= ackph_d;
      ackon_q <= ackon_d;
      co_q    <= co_d;
      dc_q    <= dc_d;
      cv_q    <= cv_d;
      cb_q    <= cb_d;
      col_q   <= col_d;
      pg_q    <= pg_d;
      busy_q  <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display ram, one byte per page column, bit 0 is top row
  logic [7:0] ram_q [PAGES*COLS];
  logic [7:0] ram_d [PAGES*COLS];
  logic [7:0] rdat_q, rdat_d;

  generate
    for (genvar i = 0; i < PAGES * COLS; i++) begin : g_ram
      always_comb begin
        ram_d[i] = ram_q[i];
        if (wr_d && (int'(pg_q) * COLS + int'(col_q)) == i) begin
          ram_d[i] = sh_q; // whole column
        end
      end
      always_ff @(posedge clk_sys) begin
        ram_q[i] <= ram_d[i];
      end
    end
  endgenerate

  always_comb begin
    rdat_d = 8'h00;
    if (int'(rd_col) < COLS) begin
      rdat_d = ram_q[int'(rd_page) * COLS + int'(rd_col)];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdat_q <= 8'h00;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; sda only ever pulled low
  assign sda_out    = 1'h0;
  assign sda_out_oe = ackon_q;
  assign cmd_valid  = cv_q;
  assign cmd_byte   = cb_q;
  assign rd_data    = rdat_q;
  assign col_ptr    = col_q;
  assign page_ptr   = pg_q;
  assign busy       = busy_q;
endmodule : i2wp_write_port
`default_nettype wire

// file: verif/i2wp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module i2wp_chk #(parameter int COLS = 132) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       hw_reset_n,
  input wire logic       sda_out,
  input wire logic       sda_out_oe,
  input wire logic       cmd_valid,
  input wire logic       col_load_en,
  input wire logic [2:0] page_load,
  input wire logic       page_load_en,
  input wire logic [7:0] rd_col,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] col_ptr,
  input wire logic [2:0] page_ptr,
  input wire logic       busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // filter jitter lets the ack stand six to thirteen cycles
  sequence ack_s;
    sda_out_oe [*6] ##[1:8] !sda_out_oe;
  endsequence
  drive_low_a: assert property (sda_out == 1'b0)
    else $error("sda value not low");
  ack_len_a: assert property ($rose(sda_out_oe) |-> ack_s)
    else $error("ack length wrong");
  cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe too long");
  cmd_col_a: assert property (cmd_valid && $past(hw_reset_n) && !$past(col_load_en)
    |-> $stable(col_ptr)) else $error("command moved column");
  col_step_a: assert property ($changed(col_ptr) && $past(hw_reset_n)
    && !$past(col_load_en) |-> col_ptr == $past(col_ptr) + 8'h01) else $error("bad step");
  page_hold_a: assert property ($changed(page_ptr)
    |-> $past(page_load_en) || !$past(hw_reset_n)) else $error("page moved");
  page_load_a: assert property (page_load_en && hw_reset_n
    |=> page_ptr == $past(page_load)) else $error("page load lost");
  col_max_a: assert property (col_ptr < COLS)
    else $error("column out of range");
  rd_blank_a: assert property (rd_col >= COLS |=> rd_data == 8'h00)
    else $error("read past end not zero");
  hw_clear_a: assert property (!hw_reset_n
    |=> col_ptr == 8'h00 && page_ptr == 3'h0 && !busy) else $error("reset not cleared");
endmodule : i2wp_chk
bind i2wp_write_port i2wp_chk #(.COLS(COLS)) u_chk (.clk_sys, .arst_n, .hw_reset_n,
  .sda_out, .sda_out_oe, .cmd_valid, .col_load_en, .page_load, .page_load_en, .rd_col,
  .rd_data, .col_ptr, .page_ptr, .busy);
`default_nettype wire

// file: verif/i2wp_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus master; scl stands high between frames
module i2wp_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start();
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
    #80;
  endtask : start
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #80 scl = 1'b1;
      #160 scl = 1'b0;
      #80;
    end
    sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 ack = ~sda;
    #80 scl = 1'b0;
    #80;
  endtask : wbyte
  task automatic stop();
    sda_low = 1'b1;
    #80 scl = 1'b1;
    #80 sda_low = 1'b0;
    #160;
  endtask : stop
endmodule : i2wp_master_model
`default_nettype wire

// file: verif/i2wp_write_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2wp_write_port_tb_top;
  logic       clk_sys = 1'b0;
  logic       arst_n = 1'b0;
  logic       hw_n = 1'b1;
  logic       sel = 1'b0;
  logic       cle = 1'b0;
  logic       ple = 1'b0;
  logic [7:0] cl = 8'h00;
  logic [2:0] pl = 3'h0;
  logic [7:0] rc = 8'h00;
  logic [2:0] rp = 3'h0;
  logic       scl, ml, oe, so, cv, bsy;
  logic [7:0] cb, rd, cp;
  logic [2:0] pp;
  wire        sda = ~(ml | oe);
  int         errors = 0;
  int         n_tests = 0;
  int         cyc = 0;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  i2wp_write_port uut (.clk_sys(clk_sys), .arst_n(arst_n), .hw_reset_n(hw_n), .scl_in(scl),
    .sda_in(sda), .addr_select_bit(sel), .sda_out(so), .sda_out_oe(oe), .cmd_valid(cv),
    .cmd_byte(cb), .col_load(cl), .col_load_en(cle), .page_load(pl), .page_load_en(ple),
    .rd_col(rc), .rd_page(rp), .rd_data(rd), .col_ptr(cp), .page_ptr(pp), .busy(bsy));
  i2wp_master_model m (.scl(scl), .sda_low(ml), .sda(sda));
  task automatic test_done();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] g, e, input string s);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk
  task automatic send(input logic [7:0] q[$], input logic ok);
    logic k;
    m.start();
    foreach (q[i]) begin
      m.wbyte(q[i], k);
      chk({7'h0, k}, {7'h0, ok}, "ack");
    end
    m.stop();
  endtask : send
  task automatic rdchk(input logic [2:0] p, input logic [7:0] c, e);
    @(posedge clk_sys);
    #1;
    rp = p;
    rc = c;
    @(posedge clk_sys);
    #1;
    chk(rd, e, "ram");
  endtask : rdchk
  task automatic t_reset();
    chk(cp, 8'h00, "col");
    chk({5'h0, pp}, 8'h00, "page");
    chk({6'h0, bsy, oe}, 8'h00, "idle");
  endtask : t_reset
  task automatic t_data();
    send('{8'h78, 8'h40, 8'ha5, 8'h3c}, 1'b1);
    chk(cp, 8'h02, "col");
    rdchk(3'h0, 8'h00, 8'ha5);
    rdchk(3'h0, 8'h01, 8'h3c);
  endtask : t_data
  task automatic t_cmd();
    sel = 1'b1;
    send('{8'h7a, 8'h80, 8'hae, 8'hc0, 8'h5a}, 1'b1);
    chk(cb, 8'hae, "cmd");
    rdchk(3'h0, 8'h02, 8'h5a);
    send('{8'h7a, 8'h00, 8'ha4, 8'ha6}, 1'b1);
    chk(cb, 8'ha6, "cmd");
    chk(cp, 8'h03, "col");
  endtask : t_cmd
  task automatic t_wrong();
    send('{8'h78, 8'h40, 8'hff}, 1'b0);
    send('{8'h7b, 8'h40, 8'hff}, 1'b0);
    chk(cp, 8'h03, "col");
  endtask : t_wrong
  task automatic t_load();
    cle = 1'b1;
    ple = 1'b1;
    pl = 3'h7;
    cl = 8'h82;
    @(posedge clk_sys);
    #1;
    cle = 1'b0;
    ple = 1'b0;
    send('{8'h7a, 8'hc0, 8'h81}, 1'b1);
    chk(cp, 8'h83, "col");
    rdchk(3'h7, 8'h82, 8'h81);
    rdchk(3'h7, 8'h84, 8'h00);
    hw_n = 1'b0;
    @(posedge clk_sys);
    #1;
    hw_n = 1'b1;
    t_reset();
  endtask : t_load
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset();
    t_data();
    t_cmd();
    t_wrong();
    t_load();
    test_done();
  end
endmodule : i2wp_write_port_tb_top
`default_nettype wire
